// file: hw/stx_pkg.sv
// package: opcodes, widths and timing for the skip/table/xor execution block
package stx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PROG_W = 15;
  localparam int PC_W   = 12;
  localparam int BIT_W  = 3;
  localparam int TABLE_HIGH_LATCH_W = PROG_W - DATA_W;
  localparam logic [TABLE_HIGH_LATCH_W-1:0] TABLE_HIGH_LATCH_RST = 7'h00;
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic              ZF_RST   = 1'b0;
  localparam int SKIP_CYCLES = 2;   // machine cycles of a taken skip

  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    STX_OP_NONE  = 3'h0,
    STX_OP_SKIP  = 3'h1,  // skip_if_bit_clear_op
    STX_OP_TRDC  = 3'h2,  // table_read_current_page_op
    STX_OP_TRDL  = 3'h3,  // table_read_last_page_op
    STX_OP_XORA  = 3'h4,  // acc ^= mem
    STX_OP_XOR_TO_MEMORY_OP  = 3'h5,  // xor_to_memory_op
    STX_OP_XORI  = 3'h6   // acc ^= literal
  } stx_op_t;

  // one decoded instruction
  typedef struct packed {
    stx_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0]  bit_sel;
    logic [DATA_W-1:0] literal;
  } stx_instr_t;

  // data-memory write request
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } stx_dm_wr_t;
endpackage : stx_pkg

// file: hw/stx_exec.sv
// execution unit for bit-test skip, table reads and xor forms
//
// Behaviour
// RQ1: bit-test skip reads data byte bit; when zero skips next instruction, flags untouched
// RQ2: a taken skip inserts a dummy cycle, so the instruction takes two cycles
// RQ3: when tested bit is one, execution continues sequentially with no skip
// RQ4: current-page table read addresses program word by pointer, low byte to memory
// RQ5: table reads load the word's high part into the high latch, no flags
// RQ6: last-page table read fetches from last page, bytes to latch and memory
// RQ7: xor memory into accumulator, result to accumulator, zero flag updated
// RQ8: xor to memory writes result back to data memory, zero flag updated
// RQ9: xor immediate with accumulator, result to accumulator, zero flag updated
// RQ10: zero flag set when xor result is zero else cleared; others untouched
`timescale 1ns/1ns
module stx_exec #(
  parameter int PC_W = stx_pkg::PC_W
) (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  input  wire logic                               instr_valid,
  input  wire stx_pkg::stx_instr_t                instr,
  input  wire logic [PC_W-1:0]                    pc,
  input  wire logic [stx_pkg::DATA_W-1:0]         table_pointer,
  input  wire logic [stx_pkg::DATA_W-1:0]         dm_rdata,
  input  wire logic [stx_pkg::PROG_W-1:0]         pm_rdata,
  output logic [stx_pkg::ADDR_W-1:0]              dm_raddr,
  output logic [PC_W-1:0]                         pm_addr,
  output stx_pkg::stx_dm_wr_t                     dm_wr,
  output logic                                    skip_next,
  output logic                                    dummy_cycle,
  output logic                                    busy,
  output logic [stx_pkg::DATA_W-1:0]              acc,
  output logic                                    zero_flag,
  output logic [stx_pkg::TABLE_HIGH_LATCH_W-1:0]              table_high_latch
);
  localparam int DW = stx_pkg::DATA_W;
  localparam int PW = PC_W - DW;

  // one-hot sequencing: a taken skip or table read holds a second cycle
  typedef enum logic [1:0] {
    STX_IDLE = 2'b01,
    STX_HOLD = 2'b10
  } stx_state_t;

  stx_state_t              state_q, state_d;
  logic [DW-1:0]           acc_q, acc_d;
  logic                    zf_q, zf_d;
  logic [stx_pkg::TABLE_HIGH_LATCH_W-1:0] table_high_latch_q, table_high_latch_d;
  stx_pkg::stx_dm_wr_t     wr_q, wr_d;
  logic                    skip_q, skip_d;
  logic                    dummy_q, dummy_d;
  logic [stx_pkg::ADDR_W-1:0] tbl_dst_q;

  function automatic logic is_zero(input logic [DW-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  // decode, gated by idle so a held instruction cannot retrigger
  wire         go       = instr_valid && (state_q == STX_IDLE);
  wire         op_skip  = go && (instr.op == stx_pkg::STX_OP_SKIP);
  wire         op_trdc  = go && (instr.op == stx_pkg::STX_OP_TRDC);
  wire         op_trdl  = go && (instr.op == stx_pkg::STX_OP_TRDL);
  wire         op_xora  = go && (instr.op == stx_pkg::STX_OP_XORA);
  wire         op_xor_to_memory_op  = go && (instr.op == stx_pkg::STX_OP_XOR_TO_MEMORY_OP);
  wire         op_xori  = go && (instr.op == stx_pkg::STX_OP_XORI);
  wire         bit_val  = dm_rdata[instr.bit_sel];
  wire         take     = op_skip && !bit_val;                        // RQ1
  wire [DW-1:0] xor_mem = acc_q ^ dm_rdata;
  wire [DW-1:0] xor_imm = acc_q ^ instr.literal;
  // page bits: current page from pc, last page is all ones
  wire [PW-1:0] page_cur  = pc[PC_W-1:DW];                            // RQ4
  wire [PW-1:0] page_last = {PW{1'b1}};                               // RQ6

  assign dm_raddr = instr.addr;
  assign pm_addr  = {(op_trdl ? page_last : page_cur), table_pointer};

  // next-state and result selection
  always_comb
  begin
    state_d = state_q;
    acc_d   = acc_q;
    zf_d    = zf_q;
    table_high_latch_d  = table_high_latch_q;
    wr_d    = '0;
    skip_d  = 1'b0;
    dummy_d = 1'b0;
    unique case (state_q)
      STX_IDLE:
      begin
        if (take)
        begin
          skip_d  = 1'b1;                                             // RQ1
          state_d = STX_HOLD;                                         // RQ2
        end
        if (op_trdc || op_trdl)
        begin
          table_high_latch_d  = pm_rdata[stx_pkg::PROG_W-1:DW];                   // RQ5
          wr_d    = '{we: 1'b1, addr: instr.addr, data: pm_rdata[DW-1:0]}; // RQ4
          state_d = STX_HOLD;
        end
        if (op_xora)
        begin
          acc_d = xor_mem;                                            // RQ7
          zf_d  = is_zero(xor_mem);                                   // RQ10
        end
        if (op_xor_to_memory_op)
        begin
          wr_d = '{we: 1'b1, addr: instr.addr, data: xor_mem};        // RQ8
          zf_d = is_zero(xor_mem);                                    // RQ10
        end
        if (op_xori)
        begin
          acc_d = xor_imm;                                            // RQ9
          zf_d  = is_zero(xor_imm);                                   // RQ10
        end
      end
      STX_HOLD:
      begin
        dummy_d = 1'b1;                                               // RQ2
        state_d = STX_IDLE;
      end
      default:
        state_d = STX_IDLE;
    endcase
  end

  // registers; flags change only on xor forms
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q   <= STX_IDLE;
      acc_q     <= stx_pkg::ACC_RST;
      zf_q      <= stx_pkg::ZF_RST;
      table_high_latch_q    <= stx_pkg::TABLE_HIGH_LATCH_RST;
      wr_q      <= '0;
      skip_q    <= 1'b0;
      dummy_q   <= 1'b0;
      tbl_dst_q <= '0;
    end
    else
    begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      zf_q      <= zf_d;
      table_high_latch_q    <= table_high_latch_d;
      wr_q      <= wr_d;
      skip_q    <= skip_d;
      dummy_q   <= dummy_d;
      tbl_dst_q <= instr.addr;
    end
  end

  assign dm_wr            = wr_q;
  assign skip_next        = skip_q;
  assign dummy_cycle      = dummy_q;
  assign busy             = (state_q == STX_HOLD);
  assign acc              = acc_q;
  assign zero_flag        = zf_q;
  assign table_high_latch = table_high_latch_q;

  AST_SKIP_TAKEN: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    take |=> skip_next && !dm_wr.we)
    else $error("taken skip not flagged");
  AST_SKIP_DUMMY: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    take |=> busy ##1 (dummy_cycle && !busy))
    else $error("skip lacks dummy cycle");
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
    (op_skip && bit_val) |=> !skip_next && !busy)
    else $error("skip on set bit");
  AST_TRDC_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
    op_trdc |=> dm_wr.we && dm_wr.data == $past(pm_rdata[DW-1:0])
      && dm_wr.addr == tbl_dst_q)
    else $error("table read low byte wrong");
  AST_TABLE_HIGH_LATCH_LOAD: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
    (op_trdc || op_trdl) |=> table_high_latch == $past(pm_rdata[stx_pkg::PROG_W-1:DW])
      && $stable(zero_flag))
    else $error("high latch or flag wrong");
  AST_TRDL_PAGE: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
    op_trdl |-> pm_addr[PC_W-1:DW] == {PW{1'b1}} && pm_addr[DW-1:0] == table_pointer)
    else $error("last page address wrong");
  AST_XORA: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
    op_xora |=> acc == ($past(acc) ^ $past(dm_rdata)))
    else $error("xor into acc wrong");
  AST_XOR_TO_MEMORY_OP: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    op_xor_to_memory_op |=> dm_wr.we && dm_wr.data == ($past(acc) ^ $past(dm_rdata)) && $stable(acc))
    else $error("xor to memory wrong");
  AST_XORI: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    op_xori |=> acc == ($past(acc) ^ $past(instr.literal)))
    else $error("xor immediate wrong");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
    (op_xora || op_xori) |=> zero_flag == (acc == 8'h00))
    else $error("zero flag wrong");

  // skip and hold sequencing: a refused request must leave no trace at all
  AST_SKIP_FLAGS: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    op_skip |=> $stable(acc) && $stable(zero_flag) && !dm_wr.we)
    else $error("skip disturbed state");
  AST_HOLD_REFUSE: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    (busy && instr_valid) |=> $stable(acc) && $stable(zero_flag) && !dm_wr.we && !skip_next)
    else $error("instruction accepted while busy");
  AST_DUMMY_AFTER_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    dummy_cycle |-> $past(busy))
    else $error("dummy cycle without hold");
  AST_STATE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    $onehot(state_q))
    else $error("sequencer state not one-hot");
  // table read and xor side effects: writes only where the rule asks for them
  AST_TRDC_PAGE: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
    op_trdc |-> pm_addr == {pc[PC_W-1:DW], table_pointer})
    else $error("current page address wrong");
  AST_TRDL_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
    op_trdl |=> dm_wr.we && dm_wr.data == $past(pm_rdata[DW-1:0])
      && table_high_latch == $past(pm_rdata[stx_pkg::PROG_W-1:DW]))
    else $error("last page read delivery wrong");
  AST_XORA_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
    op_xora |=> !dm_wr.we)
    else $error("xor into acc wrote memory");
  AST_XORI_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    op_xori |=> !dm_wr.we)
    else $error("xor immediate wrote memory");
  AST_ZERO_MEM: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
    op_xor_to_memory_op |=> zero_flag == (dm_wr.data == 8'h00))
    else $error("zero flag wrong after xor to memory");
endmodule : stx_exec

// file: dv/test_skip_table_xor_exec.sv
// self-checking bench for the skip, table-read and xor execution block
`timescale 1ns/1ns
module test_skip_table_xor_exec;
  logic                       clk = 1'b0;
  logic                       rst_b = 1'b0;
  logic                       instr_valid = 1'b0;
  stx_pkg::stx_instr_t        instr = '0;
  logic [stx_pkg::PC_W-1:0]   pc = '0;
  logic [7:0]                 table_pointer = '0;
  logic [7:0]                 dm_rdata = '0;
  logic [14:0]                pm_rdata;
  logic [7:0]                 dm_raddr;
  logic [stx_pkg::PC_W-1:0]   pm_addr;
  stx_pkg::stx_dm_wr_t        dm_wr;
  logic                       skip_next;
  logic                       dummy_cycle;
  logic                       busy;
  logic [7:0]                 acc;
  logic                       zero_flag;
  logic [6:0]                 table_high_latch;
  int                         num_errors = 0;
  int                         comparisons = 0;
  int                         cycles = 0;

  // program word depends on page bits, so a wrong page shows in the latch
  assign pm_rdata = {pm_addr[11:5], pm_addr[7:0]};

  always #10 clk = ~clk;

  stx_exec uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .pc(pc), .table_pointer(table_pointer), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata),
    .dm_raddr(dm_raddr), .pm_addr(pm_addr), .dm_wr(dm_wr), .skip_next(skip_next),
    .dummy_cycle(dummy_cycle), .busy(busy), .acc(acc), .zero_flag(zero_flag),
    .table_high_latch(table_high_latch));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // one instruction for one cycle; returns at the negedge where results are visible
  task automatic run(input stx_pkg::stx_op_t op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] lit, input logic [7:0] d);
    @(negedge clk);
    instr_valid = 1'b1;
    instr = '{op: op, addr: a, bit_sel: b, literal: lit};
    dm_rdata = d;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : run

  task automatic t_xor();
    run(stx_pkg::STX_OP_XORA, 8'h21, 3'h0, 8'h00, 8'h5a);
    check("acc xor mem", 16'h005a, {8'h00, acc});
    check("zf clear", 16'h0000, {15'h0, zero_flag});
    run(stx_pkg::STX_OP_XORI, 8'h00, 3'h0, 8'h5a, 8'hff);
    check("acc xor imm", 16'h0001, {acc, 7'h0, zero_flag});
    run(stx_pkg::STX_OP_XORI, 8'h00, 3'h0, 8'h3c, 8'h00);
    run(stx_pkg::STX_OP_XOR_TO_MEMORY_OP, 8'h44, 3'h0, 8'h00, 8'h3c);
    check("xor_to_memory_op write", 16'h0144, {7'h0, dm_wr.we, dm_wr.addr});
    check("xor_to_memory_op data", 16'h3c00, {acc, dm_wr.data});
    check("xor_to_memory_op zf", 16'h0001, {15'h0, zero_flag});
    check("read addr", 16'h0044, {8'h00, dm_raddr});
  endtask : t_xor

  // every bit position, taken and not taken; flags hold 3c and 1 from before
  task automatic t_skip();
    for (int i = 0; i < 8; i++)
    begin
      run(stx_pkg::STX_OP_SKIP, 8'h10, 3'(i), 8'h00, ~(8'h01 << i));
      check("skip taken", 16'h0003, {14'h0, busy, skip_next});
      @(negedge clk);
      check("dummy", 16'h0001, {14'h0, busy, dummy_cycle});
      run(stx_pkg::STX_OP_SKIP, 8'h10, 3'(i), 8'h00, 8'h01 << i);
      check("no skip", 16'h0000, {13'h0, busy, skip_next, dummy_cycle});
      check("skip flags", 16'h0079, {7'h0, acc, zero_flag});
    end
  endtask : t_skip

  task automatic t_table(input stx_pkg::stx_op_t op, input logic [11:0] pcv,
                         input logic [7:0] tp);
    logic [11:0] a;
    a = {(op == stx_pkg::STX_OP_TRDL) ? 4'hf : pcv[11:8], tp};
    @(negedge clk);
    pc = pcv;
    table_pointer = tp;
    instr_valid = 1'b1;
    instr = '{op: op, addr: 8'h30, bit_sel: 3'h0, literal: 8'h00};
    @(negedge clk);
    // valid stays up: an xor offered during the hold cycle must be dropped
    instr = '{op: stx_pkg::STX_OP_XORI, addr: 8'h00, bit_sel: 3'h0, literal: 8'hff};
    check("table write", 16'h0130, {7'h0, dm_wr.we, dm_wr.addr});
    check("table low", {8'h00, a[7:0]}, {8'h00, dm_wr.data});
    check("table latch", {9'h0, a[11:5]}, {9'h0, table_high_latch});
    check("table flags", 16'h0079, {7'h0, acc, zero_flag});
    check("table busy", 16'h0001, {15'h0, busy});
    @(negedge clk);
    instr_valid = 1'b0;
    check("table dummy", 16'h0001, {14'h0, busy, dummy_cycle});
    check("refused xor", 16'h0079, {7'h0, acc, zero_flag});
    check("write pulse", 16'h0000, {15'h0, dm_wr.we});
  endtask : t_table

  task automatic end_of_test();
    $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // the sequence needs about 56 cycles, so 1000 means a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check("reset state", 16'h0000, {acc, zero_flag, table_high_latch});
    t_xor();
    t_skip();
    t_table(stx_pkg::STX_OP_TRDC, 12'h3a5, 8'h9c);
    t_table(stx_pkg::STX_OP_TRDL, 12'h3a5, 8'h61);
    end_of_test();
  end
endmodule : test_skip_table_xor_exec
